// [hc_haptic_host.sv]
// Host controller driving a haptic driver over its two-wire serial bus
// How it works
// - Reads first send a write phase holding only the register address.
// - After repeated start, address with read bit; device returns data.
// - Host answers the last read byte with no-acknowledge, then stop.
// - Multi-byte read: host acknowledges every byte except the last.
// - Rotating-mass open loop: clear actuator bit, set its open-loop bit.
// - Linear-resonant open loop: set actuator bit and its open-loop bit.
// - Writing 0x07 to 0x01 leaves standby and selects auto-calibration.
// - Writing 0x01 to 0x0c starts calibration; go clears when done.
// - Host loads calibration inputs before starting calibration.
// - Host raises the enable pin before configuring or calibrating.
// - Writing 0x01 to 0x1e programs fuses; status bit then reads 1.
// - After reset the fuse values reload; host reads them back.
`include "hc_defs.svh"

module hc_haptic_host
   import hc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire hc_apb_req_t apb_req,
   output hc_apb_rsp_t apb_rsp,
   // Device pins
   input wire logic scl_i,
   input wire logic sda_i,
   output hc_i2c_out_t i2c_out,
   output logic dev_enable
);

   ////////////////////////////////////////////////////////////////////////////

   hc_regs_t r;
   hc_regs_t next_r;
   hc_xact_t xc;
   logic acc;
   logic wr;
   logic tx;
   logic [7:0] dev_w;

   // Transaction list of each command
   function automatic hc_xact_t step_of(input hc_op_t op, input logic [2:0] idx,
                                        input logic [7:0] rb, input logic lra,
                                        input logic [31:0] cmd);
      hc_xact_t x;
      x = '0;
      unique case (op)
         HC_OP_WRITE: begin
            x.last = 1'b1;
            x.ra = cmd[`HC_CMD_REG_LSB +: 8];
            x.wd = cmd[`HC_CMD_DATA_LSB +: 8];
         end
         HC_OP_READ: begin
            x.last = 1'b1;
            x.rd = 1'b1;
            x.ra = cmd[`HC_CMD_REG_LSB +: 8];
            x.len = cmd[`HC_CMD_LEN_LSB +: 3];
         end
         HC_OP_MODE: begin
            // Read-modify-write keeps the other fields of both registers
            case (idx)
               3'h0: begin
                  x.rd = 1'b1;
                  x.ra = `HC_REG_FEEDBACK;
               end
               3'h1: begin
                  x.ra = `HC_REG_FEEDBACK;
                  x.wd = lra ? (rb | (8'h01 << `HC_BIT_ACT)) : (rb & ~(8'h01 << `HC_BIT_ACT));
               end
               3'h2: begin
                  x.rd = 1'b1;
                  x.ra = `HC_REG_CTRL3;
               end
               default: begin
                  x.last = 1'b1;
                  x.ra = `HC_REG_CTRL3;
                  x.wd = rb | (lra ? (8'h01 << `HC_BIT_LRA_OL) : (8'h01 << `HC_BIT_ERM_OL));
               end
            endcase
         end
         HC_OP_CAL: begin
            // Inputs are loaded by earlier plain writes before this command
            case (idx)
               3'h0: begin
                  x.ra = `HC_REG_MODE;
                  x.wd = `HC_VAL_AUTOCAL;
               end
               3'h1: begin
                  x.ra = `HC_REG_GO;
                  x.wd = `HC_VAL_GO;
               end
               3'h2: begin
                  x.rd = 1'b1;
                  x.ra = `HC_REG_GO;
               end
               default: begin
                  x.last = 1'b1;
                  x.rd = 1'b1;
                  x.ra = `HC_REG_STATUS;
               end
            endcase
         end
         HC_OP_FUSE: begin
            case (idx)
               3'h1: begin
                  x.ra = `HC_REG_FUSE;
                  x.wd = `HC_VAL_FUSE;
               end
               default: begin
                  x.last = (idx != 3'h0);
                  x.rd = 1'b1;
                  x.ra = `HC_REG_FUSE;
               end
            endcase
         end
         HC_OP_RELOAD: begin
            case (idx)
               3'h0: begin
                  x.ra = `HC_REG_MODE;
                  x.wd = `HC_VAL_RESET;
               end
               default: begin
                  x.last = 1'b1;
                  x.rd = 1'b1;
                  x.ra = `HC_REG_DRIVE;
                  x.len = `HC_FUSE_LEN;
               end
            endcase
         end
         default: x = '0;
      endcase
      return x;
   endfunction

   function automatic logic hc_mapped(input logic [11:0] a);
      return (a == `HC_OFS_CTRL) || (a == `HC_OFS_CMD) || (a == `HC_OFS_STAT) ||
             (a == `HC_OFS_RD0) || (a == `HC_OFS_RD1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   assign xc = step_of(r.op, r.step, r.rbuf[0], r.lra, r.cmd);
   assign acc = apb_req.psel && apb_req.penable;
   assign wr = acc && apb_req.pwrite && hc_mapped(apb_req.paddr);
   assign tx = (r.stage != HC_STG_RDATA);
   // Broadcast only for writes; a read from many drivers would collide
   assign dev_w = {(r.bcast && !xc.rd) ? `HC_ADDR_BCAST : `HC_ADDR_SINGLE, 1'b0};

   // Zero-wait slave
   always_comb begin
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = acc && !hc_mapped(apb_req.paddr);
      apb_rsp.prdata = 32'h0;
      case (apb_req.paddr)
         `HC_OFS_CTRL: apb_rsp.prdata = {29'h0, r.lra, r.bcast, r.en_pin};
         `HC_OFS_CMD: apb_rsp.prdata = r.cmd;
         `HC_OFS_STAT: apb_rsp.prdata = {26'h0, r.fused, r.fault, r.refused, r.nack, r.done,
                                         r.st != HC_IDLE};
         `HC_OFS_RD0: apb_rsp.prdata = r.rbuf[3:0];
         `HC_OFS_RD1: apb_rsp.prdata = r.rbuf[7:4];
         default: apb_rsp.prdata = 32'h0;
      endcase
   end

   assign i2c_out.scl_o = 1'b0;
   assign i2c_out.scl_oe = r.scl_drv;
   assign i2c_out.sda_o = 1'b0;
   assign i2c_out.sda_oe = r.sda_drv;
   assign dev_enable = r.en_pin;

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      next_r = r;
      next_r.scl_s1 = scl_i;
      next_r.scl_s2 = r.scl_s1;
      next_r.sda_s1 = sda_i;
      next_r.sda_s2 = r.sda_s1;

      // Clears first so that a hardware set in the same cycle wins
      if (wr && apb_req.paddr == `HC_OFS_STAT) begin
         if (apb_req.pwdata[`HC_STAT_DONE]) next_r.done = 1'b0;
         if (apb_req.pwdata[`HC_STAT_NACK]) next_r.nack = 1'b0;
         if (apb_req.pwdata[`HC_STAT_REFUSED]) next_r.refused = 1'b0;
      end
      if (wr && apb_req.paddr == `HC_OFS_CTRL) begin
         next_r.en_pin = apb_req.pwdata[`HC_CTRL_EN];
         next_r.bcast = apb_req.pwdata[`HC_CTRL_BCAST];
         next_r.lra = apb_req.pwdata[`HC_CTRL_LRA];
      end

      if (r.st != HC_IDLE) begin
         if (r.tmr != 7'h0) begin
            next_r.tmr = r.tmr - 7'h1;
         end else if (r.ph == 2'h2 && !r.scl_s2) begin
            // Clock held low by the device: wait
            next_r.tmr = 7'h0;
         end else begin
            next_r.tmr = 7'(`HC_QTR_CYC - 1);
            next_r.ph = r.ph + 2'h1;
            if (r.ph == 2'h1) next_r.scl_drv = 1'b0;
            unique case (r.st)
               HC_IDLE: ;
               HC_START: begin
                  if (r.ph == 2'h0) next_r.sda_drv = 1'b0;
                  if (r.ph == 2'h2) next_r.sda_drv = 1'b1;
                  if (r.ph == 2'h3) begin
                     next_r.scl_drv = 1'b1;
                     next_r.st = HC_BYTE;
                     next_r.bitn = 4'h0;
                     next_r.sh = (r.stage == HC_STG_ADDR_R) ? {`HC_ADDR_SINGLE, 1'b1} : dev_w;
                  end
               end
               HC_BYTE: begin
                  if (r.ph == 2'h0) begin
                     if (r.bitn < 4'h8) next_r.sda_drv = tx && !r.sh[7];
                     else next_r.sda_drv = !tx && (r.bcnt != xc.len);
                  end
                  if (r.ph == 2'h2) begin
                     next_r.scl_drv = 1'b1;
                     if (r.bitn < 4'h8) next_r.sh = {r.sh[6:0], r.sda_s2};
                     else if (tx) next_r.miss = r.sda_s2;
                  end
                  if (r.ph == 2'h3) begin
                     next_r.bitn = r.bitn + 4'h1;
                     if (r.bitn == 4'h8) begin
                        next_r.bitn = 4'h0;
                        if (tx && r.miss) begin
                           next_r.st = HC_STOP;
                        end else begin
                           unique case (r.stage)
                              HC_STG_ADDR_W: begin
                                 next_r.stage = HC_STG_REG;
                                 next_r.sh = xc.ra;
                              end
                              HC_STG_REG: begin
                                 if (xc.rd) begin
                                    next_r.st = HC_START;
                                    next_r.stage = HC_STG_ADDR_R;
                                 end else begin
                                    next_r.stage = HC_STG_WDATA;
                                    next_r.sh = xc.wd;
                                 end
                              end
                              HC_STG_WDATA: next_r.st = HC_STOP;
                              HC_STG_ADDR_R: begin
                                 next_r.stage = HC_STG_RDATA;
                                 next_r.bcnt = 3'h0;
                              end
                              HC_STG_RDATA: begin
                                 next_r.rbuf[r.bcnt] = r.sh;
                                 next_r.bcnt = r.bcnt + 3'h1;
                                 if (r.bcnt == xc.len) next_r.st = HC_STOP;
                              end
                              default: next_r.st = HC_STOP;
                           endcase
                        end
                     end
                  end
               end
               HC_STOP: begin
                  if (r.ph == 2'h0) next_r.sda_drv = 1'b1;
                  if (r.ph == 2'h2) next_r.sda_drv = 1'b0;
                  if (r.ph == 2'h3) begin
                     next_r.st = HC_START;
                     next_r.stage = HC_STG_ADDR_W;
                     next_r.miss = 1'b0;
                     if (r.miss) begin
                        next_r.st = HC_IDLE;
                        next_r.nack = 1'b1;
                     end else if (r.op == HC_OP_CAL && r.step == 3'h2 && r.rbuf[0][`HC_BIT_GO]) begin
                        // Go still set: poll again
                        next_r.step = r.step;
                     end else begin
                        if (r.op == HC_OP_CAL && r.step == 3'h3) next_r.fault = r.rbuf[0][`HC_BIT_DIAG];
                        if (r.op == HC_OP_FUSE && r.step != 3'h1) next_r.fused = r.rbuf[0][`HC_BIT_FUSED];
                        // Already programmed fuses are never triggered again
                        if (xc.last || (r.op == HC_OP_FUSE && r.rbuf[0][`HC_BIT_FUSED])) begin
                           next_r.st = HC_IDLE;
                           next_r.done = 1'b1;
                        end else begin
                           next_r.step = r.step + 3'h1;
                        end
                     end
                  end
               end
               default: next_r.st = HC_IDLE;
            endcase
         end
      end

      if (wr && apb_req.paddr == `HC_OFS_CMD) begin
         if (r.st == HC_IDLE && r.en_pin && apb_req.pwdata[2:0] <= 3'h5) begin
            next_r.cmd = apb_req.pwdata;
            next_r.op = hc_op_t'(apb_req.pwdata[2:0]);
            next_r.step = 3'h0;
            next_r.st = HC_START;
            next_r.stage = HC_STG_ADDR_W;
            next_r.miss = 1'b0;
            next_r.ph = 2'h0;
            next_r.tmr = 7'(`HC_QTR_CYC - 1);
         end else begin
            next_r.refused = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule

// [hc_defs.svh]
// Constants for the haptic driver host controller
`ifndef HC_DEFS_SVH
`define HC_DEFS_SVH

// Device bus addresses (7 bit)
`define HC_ADDR_SINGLE 7'h5a
`define HC_ADDR_BCAST 7'h58

// Device register offsets
`define HC_REG_STATUS 8'h00
`define HC_REG_MODE 8'h01
`define HC_REG_GO 8'h0c
`define HC_REG_DRIVE 8'h16
`define HC_REG_FEEDBACK 8'h1a
`define HC_REG_CTRL3 8'h1d
`define HC_REG_FUSE 8'h1e

// Values written to the device
`define HC_VAL_AUTOCAL 8'h07
`define HC_VAL_GO 8'h01
`define HC_VAL_FUSE 8'h01
`define HC_VAL_RESET 8'h80

// Device field positions
`define HC_BIT_GO 0
`define HC_BIT_DIAG 3
`define HC_BIT_ACT 7
`define HC_BIT_ERM_OL 5
`define HC_BIT_LRA_OL 0
`define HC_BIT_FUSED 2
`define HC_FUSE_LEN 3'h4

// Own register offsets
`define HC_OFS_CTRL 12'h000
`define HC_OFS_CMD 12'h004
`define HC_OFS_STAT 12'h008
`define HC_OFS_RD0 12'h00c
`define HC_OFS_RD1 12'h010

// Own field positions
`define HC_CTRL_EN 0
`define HC_CTRL_BCAST 1
`define HC_CTRL_LRA 2
`define HC_CMD_REG_LSB 8
`define HC_CMD_DATA_LSB 16
`define HC_CMD_LEN_LSB 24
`define HC_STAT_DONE 1
`define HC_STAT_NACK 2
`define HC_STAT_REFUSED 3

// Timing
`define HC_CLK_NS 8
`define HC_BIT_NS 2500
`define HC_QTR_CYC ((`HC_BIT_NS + 4 * `HC_CLK_NS - 1) / (4 * `HC_CLK_NS))

`endif

// [hc_pkg.sv]
// Types for the haptic driver host controller
package hc_pkg;

   typedef enum logic [1:0] {
      HC_IDLE = 2'b00,
      HC_START = 2'b01,
      HC_BYTE = 2'b10,
      HC_STOP = 2'b11
   } hc_state_t;

   typedef enum logic [2:0] {
      HC_STG_ADDR_W = 3'b000,
      HC_STG_REG = 3'b001,
      HC_STG_WDATA = 3'b010,
      HC_STG_ADDR_R = 3'b011,
      HC_STG_RDATA = 3'b100
   } hc_stage_t;

   typedef enum logic [2:0] {
      HC_OP_WRITE = 3'b000,
      HC_OP_READ = 3'b001,
      HC_OP_MODE = 3'b010,
      HC_OP_CAL = 3'b011,
      HC_OP_FUSE = 3'b100,
      HC_OP_RELOAD = 3'b101
   } hc_op_t;

   typedef struct packed {
      logic last;
      logic rd;
      logic [7:0] ra;
      logic [7:0] wd;
      logic [2:0] len;
   } hc_xact_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } hc_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } hc_apb_rsp_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } hc_i2c_out_t;

   typedef struct packed {
      hc_state_t st;
      hc_stage_t stage;
      hc_op_t op;
      logic [2:0] step;
      logic [1:0] ph;
      logic [6:0] tmr;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [2:0] bcnt;
      logic miss;
      logic [7:0][7:0] rbuf;
      logic scl_drv;
      logic sda_drv;
      logic scl_s1;
      logic scl_s2;
      logic sda_s1;
      logic sda_s2;
      logic en_pin;
      logic bcast;
      logic lra;
      logic [31:0] cmd;
      logic done;
      logic nack;
      logic refused;
      logic fault;
      logic fused;
   } hc_regs_t;

endpackage

// [hc_haptic_host_sva.sv]
// Port assertions for the haptic driver host controller
`include "hc_defs.svh"
module hc_haptic_host_sva
   import hc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire hc_apb_req_t apb_req,
   input wire hc_apb_rsp_t apb_rsp,
   // Device pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire hc_i2c_out_t i2c_out,
   input wire logic dev_enable
);
   logic acc, mapped, ctrl_acc, prev_scl;
   logic [7:0] run;
   logic [2:0] ctrl_seen;
   assign acc = apb_req.psel && apb_req.penable;
   assign mapped = apb_req.paddr inside {`HC_OFS_CTRL, `HC_OFS_CMD, `HC_OFS_STAT,
      `HC_OFS_RD0, `HC_OFS_RD1};
   assign ctrl_acc = acc && apb_req.paddr == `HC_OFS_CTRL;
   ////////////////////////////////////////
   // Saturates so long idle gaps cannot wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 8'h00;
         prev_scl <= 1'b0;
         ctrl_seen <= 3'h0;
      end else begin
         prev_scl <= i2c_out.scl_oe;
         if (i2c_out.scl_oe != prev_scl) run <= 8'h00;
         else if (run != 8'hff) run <= run + 8'h01;
         if (ctrl_acc && apb_req.pwrite) ctrl_seen <= apb_req.pwdata[2:0];
      end
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ready_always_a: assert property (acc |-> apb_rsp.pready)
      else $error("access not answered at once");
   unmapped_err_a: assert property (acc && !mapped |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
      else $error("unmapped access not flagged");
   mapped_ok_a: assert property (acc && mapped |-> !apb_rsp.pslverr)
      else $error("mapped access flagged");
   enable_pin_a: assert property (ctrl_acc && apb_req.pwrite |=> dev_enable == $past(apb_req.pwdata[0]))
      else $error("enable pin not following control");
   ctrl_back_a: assert property (ctrl_acc && !apb_req.pwrite |-> apb_rsp.prdata[2:0] == ctrl_seen)
      else $error("control readback wrong");
   scl_quarter_a: assert property ($changed(i2c_out.scl_oe) |-> run >= 8'd78)
      else $error("clock pin moved too soon");
   sda_low_time_a: assert property ($changed(i2c_out.sda_oe) && i2c_out.scl_oe |-> run >= 8'd78)
      else $error("data moved too close to clock fall");
   pins_low_a: assert property (!i2c_out.scl_o && !i2c_out.sda_o)
      else $error("pin drive level not low");
endmodule
bind hc_haptic_host hc_haptic_host_sva u_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .scl_i(scl_i), .sda_i(sda_i), .i2c_out(i2c_out), .dev_enable(dev_enable));

// [hc_dev_model.sv]
// Behavioural model of the haptic driver on its two-wire bus
module hc_dev_model #(
   parameter logic CAL_FAULT = 1'b1,
   parameter int STRETCH_NS = 0
) (
   // Bus lines and enable pin
   input wire logic scl,
   input wire logic sda,
   input wire logic en,
   output logic sda_pull,
   output logic scl_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] regs [0:255];
   logic [7:0] otp [0:4];
   logic [7:0] sh, ptr, dat;
   logic [2:0] st;
   logic [3:0] n;
   logic ok, fused;
   int cal_runs, burns;
   initial begin
      for (int k = 0; k < 256; k++) regs[k] = (k >= 8'h16 && k <= 8'h1d) ? 8'(k + 8'h40) : 8'h00;
      for (int k = 0; k < 5; k++) otp[k] = regs[k + 8'h16];
      {st, n, sda_pull, scl_pull, fused, cal_runs, burns} = '0;
   end
   ////////////////////////////////////////
   task automatic store(input logic [7:0] a, input logic [7:0] d);
      regs[a] = d;
      if (a == 8'h01 && d[7]) begin
         for (int k = 0; k < 5; k++) regs[k + 8'h16] = otp[k];
         regs[8'h01] = 8'h40;
      end
      if (a == 8'h0c && d[0] && regs[8'h01][2:0] == 3'h7) begin
         // Result depends on actuator type only, resonant inputs unused
         regs[8'h19] = regs[8'h1a][7] ? 8'hc1 : 8'h81;
         regs[8'h00][3] = CAL_FAULT;
         regs[8'h0c][0] = 1'b0;
         cal_runs++;
      end
      if (a == 8'h1e) begin
         if (d[0] && !fused) begin
            for (int k = 0; k < 5; k++) otp[k] = regs[k + 8'h16];
            fused = 1'b1;
            burns++;
         end
         regs[8'h1e] = {5'h0, fused, 2'h0};
      end
   endtask
   ////////////////////////////////////////
   always @(negedge sda) if (scl) begin
      st = 3'd1;
      n = 4'd0;
   end
   always @(posedge sda) if (scl) st = 3'd0;
   always @(posedge scl) if (st != 3'd0) begin
      if (n < 4'd8) sh = {sh[6:0], sda};
      else if (st == 3'd4 && sda) st = 3'd0;
      n = n + 4'd1;
   end
   always @(negedge scl) if (st != 3'd0) begin
      if (n == 4'd8) begin
         sda_pull = 1'b1;
         case (st)
            3'd1: begin
               ok = en && (sh[7:1] == 7'h5a || (sh[7:1] == 7'h58 && !sh[0]));
               st = !ok ? 3'd0 : sh[0] ? 3'd5 : 3'd2;
               sda_pull = ok;
            end
            3'd2: begin
               ptr = sh;
               st = 3'd3;
            end
            3'd3: begin
               store(ptr, sh);
               ptr = ptr + 8'd1;
            end
            3'd4: sda_pull = 1'b0;
            default: ;
         endcase
      end else if (n == 4'd9) begin
         n = 4'd0;
         sda_pull = 1'b0;
         if (st >= 3'd4) begin
            dat = regs[ptr];
            ptr = ptr + 8'd1;
            st = 3'd4;
            sda_pull = !dat[7];
            // Slow answer: hold the clock low before the byte goes out
            scl_pull = STRETCH_NS > 0;
            #(STRETCH_NS);
            scl_pull = 1'b0;
         end
      end else if (st == 3'd4) sda_pull = !dat[4'd7 - n];
   end
endmodule

// [hc_haptic_host_test.sv]
// Self-checking bench for the haptic driver host controller
`include "hc_defs.svh"
module hc_haptic_host_test
   import hc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, dev_enable, scl, sda, sda_pull, scl_pull, err;
   hc_apb_req_t req;
   hc_apb_rsp_t rsp;
   hc_i2c_out_t pins;
   logic [31:0] rd, stat;
   int num_errors, comparisons;
   // Pulled-up lines: any party pulling low wins
   assign scl = !pins.scl_oe && !scl_pull;
   assign sda = !pins.sda_oe && !sda_pull;
   hc_haptic_host uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .scl_i(scl), .sda_i(sda), .i2c_out(pins), .dev_enable(dev_enable));
   hc_dev_model #(.CAL_FAULT(1'b1), .STRETCH_NS(1500)) dev (.scl(scl), .sda(sda),
      .en(dev_enable), .sda_pull(sda_pull), .scl_pull(scl_pull));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic hang(input int i, input int lim);
      if (i == lim) begin
         num_errors++;
         $display("ERROR t=%0t wait ran out", $time);
         tally_and_finish();
      end
   endtask
   // Leading edge keeps strobes from moving twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (rsp.pready === 1'b1) break;
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      hang(i, 16);
   endtask
   task automatic run_cmd(input logic [31:0] cmd, input logic again);
      int i;
      apb(1'b1, `HC_OFS_CMD, cmd);
      if (again) apb(1'b1, `HC_OFS_CMD, cmd);
      for (i = 0; i < 20000; i++) begin
         apb(1'b0, `HC_OFS_STAT, 32'h0);
         if (rd[`HC_STAT_DONE] === 1'b1) break;
      end
      hang(i, 20000);
      stat = rd;
      chk(stat[`HC_STAT_NACK], 1'b0);
      chk(stat[`HC_STAT_REFUSED], again);
      apb(1'b1, `HC_OFS_STAT, 32'he);
      apb(1'b0, `HC_OFS_RD0, 32'h0);
   endtask
   ////////////////////////////////////////
   task automatic setup_regs();
      apb(1'b0, 12'h014, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `HC_OFS_CMD, 32'(HC_OP_READ));
      apb(1'b0, `HC_OFS_STAT, 32'h0);
      chk(rd[3:0], 4'h8);
      chk(dev_enable, 1'b0);
      apb(1'b1, `HC_OFS_STAT, 32'h8);
      apb(1'b1, `HC_OFS_CTRL, 32'h3);
      apb(1'b0, `HC_OFS_CTRL, 32'h0);
      chk(rd[2:0], 3'h3);
      chk(dev_enable, 1'b1);
   endtask
   task automatic burn_fuses();
      run_cmd(32'(HC_OP_FUSE), 1'b0);
      chk(stat[5], 1'b1);
      chk(rd[7:0], 8'h04);
      chk(dev.burns, 1);
   endtask
   task automatic calibrate();
      run_cmd(32'(HC_OP_CAL), 1'b1);
      chk(stat[4], 1'b1);
      chk(rd[7:0], 8'h08);
      chk(dev.regs[8'h01], 8'h07);
      chk(dev.regs[8'h0c], 8'h00);
      chk(dev.cal_runs, 1);
      chk(dev.regs[8'h19], 8'h81);
   endtask
   // Fuses hold the values from before calibration, so reload undoes it
   task automatic reload();
      run_cmd(32'(HC_OP_RELOAD), 1'b0);
      chk(rd, 32'h59585756);
      apb(1'b0, `HC_OFS_RD1, 32'h0);
      chk(rd[7:0], 8'h5a);
   endtask
   initial begin
      presetn = 1'b0;
      req = '0;
      num_errors = 0;
      comparisons = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      setup_regs();
      burn_fuses();
      calibrate();
      reload();
      tally_and_finish();
   end
endmodule
